// *** src/drive_fault_consts.vh ***
// Purpose: Shared constants of the drive fault supervisor
// Assumes: 10 MHz ref_clk
// Notes: Fault codes are the decimal fault number in binary
`ifndef DRIVE_FAULT_CONSTS_VH
`define DRIVE_FAULT_CONSTS_VH

`define CLK_HZ 10000000
`define ALARM_DELAY_MS 300
`define MS_PER_S 1000
`define ALARM_DELAY_CYC ((`CLK_HZ / `MS_PER_S) * `ALARM_DELAY_MS)
`define MS_TICK_CYC (`CLK_HZ / `MS_PER_S)

`define FUNC_EXT_FAULT 8'h0C
`define FUNC_RESTART_INHIBIT 8'h0D
`define FUNC_FAULT_RESET 8'h12
`define FUNC_ALARM 8'h05

`define RSP_RISE_STOP 2'h0
`define RSP_FALL_STOP 2'h1
`define RSP_RISE_ONLY 2'h2
`define HCLR_SEL_A 2'h0
`define HCLR_SEL_B 2'h2

`define OC_RETRY_MAX 5'h03
`define OV_RETRY_MAX 5'h03
`define UV_RETRY_MAX 5'h10

`define CODE_NONE 8'h00
`define CODE_OC_BASE 8'h01
`define CODE_OV 8'h07
`define CODE_UV 8'h09
`define CODE_EXT 8'h0C
`define CODE_INHIBIT 8'h0D
`define CODE_MAINS_OV 8'h0F

`define REC_W 96
`define REC_CNT_LSB 88
`define REC_CODE_LSB 80
`define HIST_SLOT_NEWEST 2'h0
`define HIST_SLOT_MID 2'h1
`define HIST_SLOT_OLDEST 2'h2

`endif

// *** src/fault_history_mem.v ***
// Purpose: Three-slot fault record history, newest first
// Assumes: One write or clear per cycle
// Notes: Read data registered, one cycle after rdSlot
`timescale 1ns/1ps
`include "drive_fault_consts.vh"

module fault_history_mem (
  input wire ref_clk,
  input wire rst,
  input wire wrEn,
  input wire [`REC_W-1:0] wrRecord,
  input wire clearAll,
  input wire [1:0] rdSlot,
  output reg [`REC_W-1:0] rdRecord_ff
);

reg [`REC_W-1:0] slot0_ff;
reg [`REC_W-1:0] slot1_ff;
reg [`REC_W-1:0] slot2_ff;

////////////////////////////////////////////////////////////////////////
always @(posedge ref_clk)
begin
  if (rst || clearAll)
  begin
    slot0_ff <= {`REC_W{1'b0}};
    slot1_ff <= {`REC_W{1'b0}};
    slot2_ff <= {`REC_W{1'b0}};
  end
  else if (wrEn)
  begin
    slot0_ff <= wrRecord;
    slot1_ff <= slot0_ff;
    slot2_ff <= slot1_ff;  // Oldest drops out
  end
end

always @(posedge ref_clk)
begin
  if (rst)
    rdRecord_ff <= {`REC_W{1'b0}};
  else
  begin
    case (rdSlot)
      `HIST_SLOT_NEWEST: rdRecord_ff <= slot0_ff;
      `HIST_SLOT_MID: rdRecord_ff <= slot1_ff;
      `HIST_SLOT_OLDEST: rdRecord_ff <= slot2_ff;
      default: rdRecord_ff <= {`REC_W{1'b0}};
    endcase
  end
end

endmodule // fault_history_mem

// *** src/drive_fault_supervisor.v ***
// Purpose: Fault latch, alarm, reset and auto-restart supervision
// Assumes: Inputs synchronous to ref_clk; rst is the power-on reset
// Notes: Supply off-on cycle is modelled by rst
`timescale 1ns/1ps
`include "drive_fault_consts.vh"

module drive_fault_supervisor #(
  parameter [31:0] ALARM_DELAY = `ALARM_DELAY_CYC,
  parameter [31:0] MS_TICK = `MS_TICK_CYC
) (
  input wire ref_clk,
  input wire rst,
  input wire [5:0] digIn,
  input wire [47:0] digInFuncSel,
  input wire [7:0] digOut11Sel,
  input wire [7:0] digOut12Sel,
  input wire [1:0] resetResponseSelect,
  input wire [1:0] historyClearSelect,
  input wire historyClearApply,
  input wire restartLimitSelect,
  input wire [15:0] supplyLossTime,
  input wire stopKey,
  input wire forwardRunCommand,
  input wire reverseRunCommand,
  input wire supplyPresent,
  input wire overcurrentDetect,
  input wire overvoltageDetect,
  input wire mainsOvervoltageDetect,
  input wire undervoltageDetect,
  input wire [1:0] operatingState,
  input wire [15:0] outputFrequency,
  input wire [15:0] outputCurrent,
  input wire [15:0] dcLinkVoltage,
  input wire [15:0] runHours,
  input wire [15:0] powerOnHours,
  input wire [1:0] historySlotSelect,
  output wire [`REC_W-1:0] historyRecord,
  output reg signallingRelay_ff,
  output reg digOut11_ff,
  output reg digOut12_ff,
  output reg faultAlarmOutput_ff,
  output reg faultPresent_ff,
  output reg [7:0] faultCode_ff,
  output reg serialReportValid_ff,
  output reg [7:0] serialReportCode_ff,
  output reg restartPulse_ff,
  output reg motorEnable_ff
);

////////////////////////////////////////////////////////////////////////
function anyFunc;
  input [47:0] sels;
  input [5:0] pins;
  input [7:0] code;
  integer i;
  begin
    anyFunc = 1'b0;
    for (i = 0; i < 6; i = i + 1)
      if (sels[i*8 +: 8] == code && pins[i])
        anyFunc = 1'b1;
  end
endfunction

function [4:0] bump;
  input [4:0] cnt;
  begin
    bump = (cnt == 5'h1F) ? cnt : cnt + 5'h01;
  end
endfunction

////////////////////////////////////////////////////////////////////////
reg [7:0] faultCount_ff;
reg [31:0] alarmCnt_ff;
reg [31:0] msCnt_ff;
reg [15:0] downMs_ff;
reg [4:0] ocTries_ff;
reg [4:0] ovTries_ff;
reg [4:0] uvTries_ff;
reg resetPrev_ff;
reg ocPrev_ff;
reg ovPrev_ff;
reg uvPrev_ff;
reg supplyPrev_ff;
reg scanDone_ff;
reg stopHold_ff;
reg [7:0] nxt_code;
reg nxt_raise;
reg nxt_restart;

wire runCmd = forwardRunCommand | reverseRunCommand;
wire extFault = anyFunc(digInFuncSel, digIn, `FUNC_EXT_FAULT);
wire inhibitIn = anyFunc(digInFuncSel, digIn, `FUNC_RESTART_INHIBIT);
wire resetIn = anyFunc(digInFuncSel, digIn, `FUNC_FAULT_RESET);
wire resetRise = resetIn & ~resetPrev_ff;
wire resetFall = ~resetIn & resetPrev_ff;
wire rspFall = (resetResponseSelect == `RSP_FALL_STOP);
wire resetEdge = rspFall ? resetFall : resetRise;
wire resetStops = (resetResponseSelect != `RSP_RISE_ONLY);
wire ackReset = resetEdge | stopKey;
wire ocEvent = overcurrentDetect & ~ocPrev_ff;
wire ovEvent = (overvoltageDetect | mainsOvervoltageDetect) & ~ovPrev_ff;
wire uvEvent = undervoltageDetect & ~uvPrev_ff;
wire supplyBack = supplyPresent & ~supplyPrev_ff;
wire longLoss = (downMs_ff >= supplyLossTime);
wire inhibitClear = stopKey | resetIn | ~runCmd;
wire isInhibit = (faultCode_ff == `CODE_INHIBIT);
wire clearFault = faultPresent_ff & (ackReset | (isInhibit & inhibitClear));
wire msTick = (msCnt_ff == MS_TICK - 32'h1);
wire histClear = historyClearApply & ((historyClearSelect == `HCLR_SEL_A) |
  (historyClearSelect == `HCLR_SEL_B));
wire [7:0] ocCode = `CODE_OC_BASE + {6'h00, operatingState};
wire [7:0] ovCode = mainsOvervoltageDetect ? `CODE_MAINS_OV : `CODE_OV;
wire uvLimited = ~restartLimitSelect;
wire [`REC_W-1:0] newRecord = {faultCount_ff + 8'h01, nxt_code, outputFrequency,
  outputCurrent, dcLinkVoltage, runHours, powerOnHours};

////////////////////////////////////////////////////////////////////////
// Fault arbitration; one new fault at a time, first latched wins
always @*
begin
  nxt_code = `CODE_NONE;
  nxt_raise = 1'b0;
  nxt_restart = 1'b0;
  if (!faultPresent_ff)
  begin
    if (extFault)
    begin
      nxt_code = `CODE_EXT;
      nxt_raise = 1'b1;
    end
    else if (supplyBack && runCmd && inhibitIn)
    begin
      nxt_code = `CODE_INHIBIT;
      nxt_raise = 1'b1;
    end
    else if (ocEvent)
    begin
      if (ocTries_ff < `OC_RETRY_MAX)
        nxt_restart = 1'b1;
      else
      begin
        nxt_code = ocCode;
        nxt_raise = 1'b1;
      end
    end
    else if (ovEvent)
    begin
      if (ovTries_ff < `OV_RETRY_MAX)
        nxt_restart = 1'b1;
      else
      begin
        nxt_code = ovCode;
        nxt_raise = 1'b1;
      end
    end
    else if (uvEvent || (supplyBack && !longLoss))
    begin
      if (!uvLimited || uvTries_ff < `UV_RETRY_MAX)
        nxt_restart = runCmd;
      else
      begin
        nxt_code = `CODE_UV;
        nxt_raise = 1'b1;
      end
    end
    else if (supplyBack && longLoss && runCmd)
      nxt_restart = 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////
always @(posedge ref_clk)
begin
  if (rst)
  begin
    faultPresent_ff <= 1'b0;  // Power cycle acknowledges
    faultCode_ff <= `CODE_NONE;
    faultCount_ff <= 8'h00;
    ocTries_ff <= 5'h00;
    ovTries_ff <= 5'h00;
    uvTries_ff <= 5'h00;
    restartPulse_ff <= 1'b0;
    serialReportValid_ff <= 1'b0;
    serialReportCode_ff <= `CODE_NONE;
  end
  else
  begin
    restartPulse_ff <= nxt_restart;
    serialReportValid_ff <= nxt_raise;
    if (nxt_raise)
      serialReportCode_ff <= nxt_code;
    if (histClear)
      faultCount_ff <= 8'h00;
    else if (nxt_raise)
      faultCount_ff <= faultCount_ff + 8'h01;
    if (nxt_raise)
    begin
      faultPresent_ff <= 1'b1;  // Latched past input release
      faultCode_ff <= nxt_code;
    end
    else if (clearFault)
    begin
      faultPresent_ff <= 1'b0;
      faultCode_ff <= `CODE_NONE;
    end
    // Counters restart on acknowledge or healthy running
    if (clearFault || ackReset || (motorEnable_ff && !overcurrentDetect &&
      !overvoltageDetect && !undervoltageDetect && msTick))
    begin
      ocTries_ff <= 5'h00;
      ovTries_ff <= 5'h00;
      uvTries_ff <= 5'h00;
    end
    else if (nxt_restart)
    begin
      if (ocEvent)
        ocTries_ff <= bump(ocTries_ff);
      else if (ovEvent)
        ovTries_ff <= bump(ovTries_ff);
      else if (uvEvent || supplyBack)
        uvTries_ff <= bump(uvTries_ff);
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Edge history and supply-down timer in ms ticks
always @(posedge ref_clk)
begin
  if (rst)
  begin
    resetPrev_ff <= 1'b0;
    ocPrev_ff <= 1'b0;
    ovPrev_ff <= 1'b0;
    uvPrev_ff <= 1'b0;
    supplyPrev_ff <= 1'b1;
    msCnt_ff <= 32'h0;
    downMs_ff <= 16'h0000;
  end
  else
  begin
    resetPrev_ff <= resetIn;
    ocPrev_ff <= overcurrentDetect;
    ovPrev_ff <= overvoltageDetect | mainsOvervoltageDetect;
    uvPrev_ff <= undervoltageDetect;
    supplyPrev_ff <= supplyPresent;
    msCnt_ff <= msTick ? 32'h0 : msCnt_ff + 32'h1;
    if (supplyBack)
      downMs_ff <= 16'h0000;
    else if (!supplyPresent && msTick && downMs_ff != 16'hFFFF)
      downMs_ff <= downMs_ff + 16'h0001;
  end
end

////////////////////////////////////////////////////////////////////////
// Alarm delay; the count delays the alarm output and outputs 11/12, not the relay
always @(posedge ref_clk)
begin
  if (rst)
  begin
    alarmCnt_ff <= 32'h0;
    faultAlarmOutput_ff <= 1'b0;
    scanDone_ff <= 1'b0;
    signallingRelay_ff <= 1'b0;
    digOut11_ff <= 1'b0;
    digOut12_ff <= 1'b0;
  end
  else
  begin
    scanDone_ff <= 1'b1;
    if (!faultPresent_ff)
    begin
      alarmCnt_ff <= 32'h0;
      faultAlarmOutput_ff <= 1'b0;
    end
    else if (alarmCnt_ff >= ALARM_DELAY - 32'h1)
      faultAlarmOutput_ff <= 1'b1;
    else
      alarmCnt_ff <= alarmCnt_ff + 32'h1;
    // Relay is fail-safe: energized only when healthy
    signallingRelay_ff <= scanDone_ff & ~faultPresent_ff & ~faultAlarmOutput_ff;
    digOut11_ff <= (digOut11Sel == `FUNC_ALARM) & faultAlarmOutput_ff;
    digOut12_ff <= (digOut12Sel == `FUNC_ALARM) & faultAlarmOutput_ff;
  end
end

////////////////////////////////////////////////////////////////////////
// Motor enable; stopping resets hold until run command drops
always @(posedge ref_clk)
begin
  if (rst)
  begin
    stopHold_ff <= 1'b0;
    motorEnable_ff <= 1'b0;
  end
  else
  begin
    if ((resetEdge && resetStops) || stopKey)
      stopHold_ff <= 1'b1;
    else if (!runCmd)
      stopHold_ff <= 1'b0;
    // Fault reset sets no hold in mode 02, so run resumes at once
    motorEnable_ff <= runCmd & ~faultPresent_ff & ~nxt_raise & ~stopHold_ff &
      ~((resetEdge && resetStops) || stopKey) & supplyPresent;
  end
end

////////////////////////////////////////////////////////////////////////
fault_history_mem u_history (
  .ref_clk(ref_clk),
  .rst(rst),
  .wrEn(nxt_raise),
  .wrRecord(newRecord),
  .clearAll(histClear),
  .rdSlot(historySlotSelect),
  .rdRecord_ff(historyRecord)
);

endmodule // drive_fault_supervisor

// *** dv/drive_fault_checker_assertions.sv ***
// Purpose: Port checks of the drive fault supervisor
// Assumes: Input 3 ext fault, input 5 fault reset
// Notes: Alarm delay measured by a helper counter
`timescale 1ns/1ps
module drive_fault_checker #(
  parameter [31:0] ALARM_DELAY = 32'd20
) (
  input wire ref_clk,
  input wire rst,
  input wire [5:0] digIn,
  input wire [47:0] digInFuncSel,
  input wire [7:0] digOut11Sel,
  input wire [1:0] resetResponseSelect,
  input wire stopKey,
  input wire forwardRunCommand,
  input wire reverseRunCommand,
  input wire [1:0] operatingState,
  input wire signallingRelay_ff,
  input wire digOut11_ff,
  input wire faultAlarmOutput_ff,
  input wire faultPresent_ff,
  input wire [7:0] faultCode_ff,
  input wire serialReportValid_ff,
  input wire [7:0] serialReportCode_ff,
  input wire motorEnable_ff
);
  reg [31:0] faultAge_ff;
  wire [31:0] nxt_faultAge = faultPresent_ff ? faultAge_ff + 32'h1 : 32'h0;
  always @(posedge ref_clk)
  begin
    faultAge_ff <= rst ? 32'h0 : nxt_faultAge;
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_ext_raise: assert property (!faultPresent_ff && digIn[2]
    && digInFuncSel[23:16] == 8'h0C |=> faultPresent_ff && faultCode_ff == 8'h0C)
    else $error("ext fault not raised");
  a_report_pulse: assert property ($rose(faultPresent_ff) |-> serialReportValid_ff
    && serialReportCode_ff == faultCode_ff ##1 !serialReportValid_ff)
    else $error("bad serial report");
  a_ext_latch: assert property (faultPresent_ff && faultCode_ff == 8'h0C
    && !stopKey && !digIn[4] && !$past(digIn[4]) |=> faultPresent_ff)
    else $error("ext fault lost");
  // Window of one cycle either side: the delay is only nominal
  a_alarm_delay: assert property ($rose(faultAlarmOutput_ff) |-> faultPresent_ff
    && faultAge_ff + 32'h1 >= ALARM_DELAY && faultAge_ff <= ALARM_DELAY + 32'h1)
    else $error("alarm delay wrong");
  a_relay_drop: assert property (faultPresent_ff && $past(faultPresent_ff)
    |-> !signallingRelay_ff) else $error("relay held");
  a_out_alarm: assert property (digOut11_ff ==
    ($past(faultAlarmOutput_ff) && $past(digOut11Sel) == 8'h05)) else $error("out11 wrong");
  a_rise_ack: assert property (faultPresent_ff && digIn[4] && !$past(digIn[4])
    && digInFuncSel[39:32] == 8'h12 && resetResponseSelect != 2'h1 |=> !faultPresent_ff)
    else $error("rise ack missed");
  a_stop_ack: assert property (faultPresent_ff && stopKey |=> !faultPresent_ff)
    else $error("stop ack missed");
  a_resume_run: assert property (resetResponseSelect == 2'h2 && $fell(faultPresent_ff)
    && !$past(stopKey) && !stopKey && (forwardRunCommand || reverseRunCommand) |=> motorEnable_ff)
    else $error("no resume");
  a_oc_code: assert property ($rose(faultPresent_ff) && faultCode_ff >= 8'h01
    && faultCode_ff <= 8'h04 |-> faultCode_ff == 8'h01 + {6'h0, $past(operatingState)})
    else $error("oc code wrong");
endmodule // drive_fault_checker

bind drive_fault_supervisor drive_fault_checker #(.ALARM_DELAY(ALARM_DELAY)) chk (
  .ref_clk, .rst, .digIn, .digInFuncSel, .digOut11Sel, .resetResponseSelect, .stopKey,
  .forwardRunCommand, .reverseRunCommand, .operatingState, .signallingRelay_ff, .digOut11_ff,
  .faultAlarmOutput_ff, .faultPresent_ff, .faultCode_ff, .serialReportValid_ff,
  .serialReportCode_ff, .motorEnable_ff);

// *** dv/plant_inputs.sv ***
// Purpose: Plant side digital inputs
// Assumes: Input 3 ext, 4 inhibit, 5 reset
// Notes: Unused inputs toggle so a stray function shows
`timescale 1ns/1ps
module plant_inputs (
  input wire ref_clk,
  input wire extOn,
  input wire inhOn,
  input wire rstOn,
  output reg [5:0] digIn
);
  initial digIn = 6'h00;
  always @(posedge ref_clk)
  begin
    digIn <= {~digIn[5], rstOn, inhOn, extOn, ~digIn[1], ~digIn[0]};
  end
endmodule // plant_inputs

// *** dv/tb.sv ***
// Purpose: Self-checking bench of the drive fault supervisor
// Assumes: Short alarm delay, long ms tick
// Notes: Serial reports checked against a queue
`timescale 1ns/1ps
module tb;
  reg ref_clk = 0, rst = 1, extOn = 0, inhOn = 0, rstOn = 0;
  wire [5:0] digIn;
  reg [47:0] digInFuncSel = 48'h00120D0C0000;
  reg [7:0] digOut11Sel = 8'h05, digOut12Sel = 8'h00;
  reg [1:0] resetResponseSelect = 0, historyClearSelect = 1, operatingState = 0;
  reg [1:0] historySlotSelect = 0;
  reg historyClearApply = 0, restartLimitSelect = 0, stopKey = 0, supplyPresent = 1;
  reg forwardRunCommand = 0, reverseRunCommand = 0, mainsOvervoltageDetect = 0;
  // Mains detect must pulse with the others or its edge is seen only once
  reg mainsOn = 0;
  reg overcurrentDetect = 0, overvoltageDetect = 0, undervoltageDetect = 0;
  reg [15:0] supplyLossTime = 1, outputFrequency = 0, outputCurrent = 0;
  reg [15:0] dcLinkVoltage = 0, runHours = 0, powerOnHours = 0;
  wire [95:0] historyRecord;
  wire signallingRelay_ff, digOut11_ff, digOut12_ff, faultAlarmOutput_ff, faultPresent_ff;
  wire serialReportValid_ff, restartPulse_ff, motorEnable_ff;
  wire [7:0] faultCode_ff, serialReportCode_ff;
  integer bad_count = 0, comparisons = 0, pulses = 0, i;
  logic [7:0] expCodes[$];
  // Long ms tick keeps restart counters from clearing mid-burst
  drive_fault_supervisor #(.ALARM_DELAY(32'd20), .MS_TICK(32'd40000)) dut (.*);
  plant_inputs plant (.ref_clk, .extOn, .inhOn, .rstOn, .digIn);
  always #50 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////
  task tick(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  task check(input logic [95:0] got, input logic [95:0] exp);
    begin
      comparisons++;
      if (got !== exp)
      begin
        bad_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wait_fault(input logic v);
    begin
      for (i = 0; i < 60 && faultPresent_ff !== v; i++) tick(1);
      check(faultPresent_ff, v);
    end
  endtask
  task hist(input [1:0] s, input [15:0] cntCode);
    begin
      historySlotSelect <= s;
      tick(2);
      check(historyRecord[95:80], cntCode);
    end
  endtask
  task stop_ack;
    begin
      stopKey <= 1;
      tick(1);
      stopKey <= 0;
      wait_fault(0);
    end
  endtask
  task pulse(input integer k, input integer n);
    integer j;
    begin
      pulses = 0;
      for (j = 0; j < n; j++)
      begin
        {undervoltageDetect, overvoltageDetect, overcurrentDetect} <= 3'h1 << k;
        mainsOvervoltageDetect <= mainsOn && k == 1;
        tick(3);
        {undervoltageDetect, overvoltageDetect, overcurrentDetect} <= 3'h0;
        mainsOvervoltageDetect <= 1'b0;
        tick(1);
      end
      tick(3);
    end
  endtask
  task print_verdict;
    begin
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge ref_clk)
  begin
    if (restartPulse_ff === 1'b1)
      pulses++;
    if (serialReportValid_ff === 1'b1)
      check(serialReportCode_ff, expCodes.size() ? expCodes.pop_front() : 8'hFF);
  end
  initial
  begin
    tick(30000);
    bad_count++;
    print_verdict;
  end
  initial
  begin
    void'($urandom(6703));
    tick(6);
    rst <= 0;
    tick(4);
    check(signallingRelay_ff, 1);
    {outputFrequency, outputCurrent, dcLinkVoltage} <= {$urandom, $urandom};
    {runHours, powerOnHours} <= $urandom;
    digOut12Sel <= 8'h05;
    expCodes.push_back(8'h0C);
    extOn <= 1;
    wait_fault(1);
    extOn <= 0;
    hist(0, 16'h010C);
    check(historyRecord, {8'h01, 8'h0C, outputFrequency, outputCurrent, dcLinkVoltage,
      runHours, powerOnHours});
    for (i = 0; i < 60 && faultAlarmOutput_ff !== 1'b1; i++) tick(1);
    tick(2);
    check({digOut11_ff, digOut12_ff, signallingRelay_ff, faultPresent_ff}, 4'hD);
    rstOn <= 1;
    tick(1);
    rstOn <= 0;
    wait_fault(0);
    tick(3);
    check({signallingRelay_ff, faultAlarmOutput_ff}, 2'h2);
    resetResponseSelect <= 2;
    reverseRunCommand <= 1;
    expCodes.push_back(8'h0C);
    extOn <= 1;
    wait_fault(1);
    extOn <= 0;
    hist(1, 16'h010C);
    rstOn <= 1;
    tick(1);
    rstOn <= 0;
    wait_fault(0);
    tick(2);
    check(motorEnable_ff, 1);
    reverseRunCommand <= 0;
    operatingState <= 2'($urandom);
    tick(1);
    expCodes.push_back(8'h01 + {6'h0, operatingState});
    pulse(0, 4);
    check({pulses, faultPresent_ff}, {32'd3, 1'b1});
    hist(0, {8'h03, 8'h01 + {6'h0, operatingState}});
    stop_ack;
    mainsOn = 1;
    expCodes.push_back(8'h0F);
    pulse(1, 4);
    check({pulses, faultPresent_ff}, {32'd3, 1'b1});
    stop_ack;
    mainsOn = 0;
    forwardRunCommand <= 1;
    expCodes.push_back(8'h09);
    pulse(2, 17);
    check({pulses, faultPresent_ff}, {32'd16, 1'b1});
    stop_ack;
    forwardRunCommand <= 0;
    restartLimitSelect <= 1;
    tick(2);
    forwardRunCommand <= 1;
    pulse(2, 20);
    check({pulses, faultPresent_ff}, {32'd20, 1'b0});
    inhOn <= 1;
    supplyPresent <= 0;
    tick(3);
    expCodes.push_back(8'h0D);
    supplyPresent <= 1;
    wait_fault(1);
    check(motorEnable_ff, 0);
    forwardRunCommand <= 0;
    wait_fault(0);
    inhOn <= 0;
    hist(0, 16'h060D);
    historyClearApply <= 1;
    tick(1);
    historyClearApply <= 0;
    hist(0, 16'h060D);
    historyClearSelect <= 2;
    historyClearApply <= 1;
    tick(1);
    historyClearApply <= 0;
    hist(1, 16'h0000);
    check(expCodes.size(), 0);
    print_verdict;
  end
endmodule // tb
